// *** rtl/bodr_engine.sv ***
// Engine: block output with decrement and repeat, memory to fixed I/O port
`default_nettype none
// What this block does
// - each pass reads memory at the source pointer, writes it to the port.
// - the port address is driven as sixteen bits on every output.
// - the pointer drops by one, two or four after each transfer.
// - the counter drops by one; repeat unless the new count is zero.
// - the port address register never changes during the run; only the next accepted start reloads it.
// - one to 65536 elements; a zero start count wraps to the maximum.
// - on completion set overflow, leave every other flag alone.
// - without system privilege raise the trap and do no transfer.
// - compact mode uses a word pointer, linear mode a full address.
// - addresses descend, wrapping at zero; final pointer one element below last.
module bodr_engine
    import bodr_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        start,
    input  wire bodr_size_t  elemSize,
    input  wire logic        sysMode,
    input  wire logic        linearMode,
    input  wire logic [31:0] srcPtrIn,
    input  wire logic [15:0] portAddrIn,
    input  wire logic [15:0] countIn,
    input  wire logic [5:0]  flagsIn,
    output logic             memReq,
    output logic [31:0]      memAddr,
    output bodr_size_t       memSize,
    input  wire logic        memAck,
    input  wire logic [31:0] memData,
    output logic             ioReq,
    output logic [15:0]      ioPort,
    output logic [31:0]      ioData,
    output bodr_size_t       ioSize,
    input  wire logic        ioAck,
    output logic             busy,
    output logic             done,
    output logic             privTrap,
    output logic [31:0]      srcPtrOut,
    output logic [15:0]      countOut,
    output logic [15:0]      portAddrOut,
    output logic [5:0]       flagsOut
);
    // ==========================================================
    // Declarations
    typedef enum {ST_IDLE, ST_READ, ST_WRITE, ST_STEP} bodr_state_t;
    bodr_state_t state_reg;
    logic [31:0] ptr_reg;
    logic [15:0] cnt_reg;
    logic [15:0] port_reg;
    logic [31:0] data_reg;
    bodr_size_t  size_reg;
    logic        linear_reg;
    logic        done_reg;
    logic        trap_reg;
    logic [5:0]  flags_reg;
    logic        accept;
    bodr_step_if st ();

    // ==========================================================
    // Step unit
    assign st.ptr    = ptr_reg;
    assign st.count  = cnt_reg;
    assign st.size   = size_reg;
    assign st.linear = linear_reg;
    bodr_step u_step (.st(st.stepper));

    assign accept = (state_reg == ST_IDLE) && start && sysMode;

    // ==========================================================
    // Sequencer
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE:  if (accept) state_reg <= ST_READ;
                ST_READ:  if (memAck) state_reg <= ST_WRITE;
                ST_WRITE: if (ioAck) state_reg <= ST_STEP;
                ST_STEP:  state_reg <= st.countZero ? ST_IDLE : ST_READ;
                default:  state_reg <= ST_IDLE;
            endcase
        end
    end

    // Operand capture; port address loaded once and held
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            port_reg   <= BODR_PORT_RST;
            size_reg   <= BODR_WORD;
            linear_reg <= 1'b0;
        end else if (accept) begin
            port_reg   <= portAddrIn;
            size_reg   <= elemSize;
            linear_reg <= linearMode;
        end
    end

    // Pointer and counter update after each output
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ptr_reg <= BODR_PTR_RST;
            cnt_reg <= BODR_CNT_RST;
        end else if (accept) begin
            ptr_reg <= linearMode ? srcPtrIn : {16'h0000, srcPtrIn[15:0]};
            cnt_reg <= countIn;
        end else if (state_reg == ST_STEP) begin
            ptr_reg <= st.ptrNext;
            cnt_reg <= st.countNext;
        end
    end

    // Element captured from memory
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            data_reg <= 32'h0000_0000;
        end else if (state_reg == ST_READ && memAck) begin
            data_reg <= memData;
        end
    end

    // Completion, trap and flags
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            done_reg  <= 1'b0;
            trap_reg  <= 1'b0;
            flags_reg <= BODR_FLAG_RST;
        end else begin
            done_reg <= (state_reg == ST_STEP) && st.countZero;
            trap_reg <= (state_reg == ST_IDLE) && start && !sysMode;
            if (accept) begin
                flags_reg <= flagsIn;
            end else if (state_reg == ST_STEP && st.countZero) begin
                flags_reg[BODR_FLAG_V] <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Outputs
    assign memReq      = (state_reg == ST_READ);
    assign memAddr     = ptr_reg;
    assign memSize     = size_reg;
    assign ioReq       = (state_reg == ST_WRITE);
    assign ioPort      = port_reg;
    assign ioData      = data_reg;
    assign ioSize      = size_reg;
    assign busy        = (state_reg != ST_IDLE);
    assign done        = done_reg;
    assign privTrap    = trap_reg;
    assign srcPtrOut   = ptr_reg;
    assign countOut    = cnt_reg;
    assign portAddrOut = port_reg;
    assign flagsOut    = flags_reg;

    // ==========================================================
    // Assertions
    AST_PORT_HELD: assert property (@(posedge mclk) disable iff (!rstn)
        busy && !accept |=> $stable(port_reg))
        else $error("port address changed during run");
    AST_PTR_STEP: assert property (@(posedge mclk) disable iff (!rstn)
        (state_reg == ST_STEP) && linear_reg |=> ptr_reg == $past(ptr_reg) -
        ((size_reg == BODR_BYTE) ? 32'h1 : (size_reg == BODR_LONG) ? 32'h4 : 32'h2))
        else $error("pointer step wrong");
    AST_CNT_STEP: assert property (@(posedge mclk) disable iff (!rstn)
        state_reg == ST_STEP |=> cnt_reg == $past(cnt_reg) - 16'h0001)
        else $error("counter step wrong");
    AST_DONE_ZERO: assert property (@(posedge mclk) disable iff (!rstn)
        done |-> cnt_reg == 16'h0000 && !busy)
        else $error("done with nonzero count");
    AST_V_SET: assert property (@(posedge mclk) disable iff (!rstn)
        done |-> flags_reg[BODR_FLAG_V] &&
        flags_reg[5:4] == $past(flags_reg[5:4]) && flags_reg[2:0] == $past(flags_reg[2:0]))
        else $error("flags wrong at completion");
    AST_TRAP_NO_IO: assert property (@(posedge mclk) disable iff (!rstn)
        (state_reg == ST_IDLE) && start && !sysMode |=> privTrap && !busy ##1 !ioReq)
        else $error("trap did not block transfer");
    AST_COMPACT: assert property (@(posedge mclk) disable iff (!rstn)
        busy && !linear_reg |-> memAddr[31:16] == 16'h0000)
        else $error("compact pointer exceeds a word");
    AST_IO_AFTER_READ: assert property (@(posedge mclk) disable iff (!rstn)
        memReq && memAck |=> ioReq && ioData == $past(memData))
        else $error("output not the element read");
    AST_SIZE_MATCH: assert property (@(posedge mclk) disable iff (!rstn)
        ioReq |-> ioSize == memSize)
        else $error("io width differs from element");
    AST_DESCEND: assert property (@(posedge mclk) disable iff (!rstn)
        (state_reg == ST_STEP) && !st.countZero && linear_reg |=> memAddr < $past(memAddr))
        else $error("addresses not descending");
    // Compact pointer steps inside its own sixteen bits
    AST_PTR_COMPACT: assert property (@(posedge mclk) disable iff (!rstn)
        (state_reg == ST_STEP) && !linear_reg |=> ptr_reg[15:0] == $past(ptr_reg[15:0]) -
        ((size_reg == BODR_BYTE) ? 16'h1 : (size_reg == BODR_LONG) ? 16'h4 : 16'h2))
        else $error("compact pointer step wrong");
    // Zero start count wraps instead of ending the run
    AST_ZERO_WRAP: assert property (@(posedge mclk) disable iff (!rstn)
        (state_reg == ST_STEP) && cnt_reg == 16'h0000 |=> state_reg == ST_READ &&
        cnt_reg == 16'hFFFF)
        else $error("zero count did not wrap");
    AST_SIZE_TAKEN: assert property (@(posedge mclk) disable iff (!rstn)
        accept |=> memSize == $past(elemSize) && ioSize == $past(elemSize))
        else $error("element size not taken");
    AST_FLAGS_LOAD: assert property (@(posedge mclk) disable iff (!rstn)
        accept |=> flags_reg == $past(flagsIn))
        else $error("flags not taken at start");
    AST_TRAP_KEEPS: assert property (@(posedge mclk) disable iff (!rstn)
        (state_reg == ST_IDLE) && start && !sysMode |=> $stable(flags_reg) &&
        $stable(ptr_reg) && $stable(cnt_reg) && $stable(port_reg))
        else $error("refused start changed state");
    // Requests hold until answered
    AST_MEM_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
        memReq && !memAck |=> memReq && $stable(memAddr))
        else $error("memory request dropped early");
    AST_IO_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
        ioReq && !ioAck |=> ioReq && $stable(ioData) && $stable(ioPort))
        else $error("output request dropped early");

    COV_DONE: cover property (@(posedge mclk) disable iff (!rstn) done);
    COV_TRAP: cover property (@(posedge mclk) disable iff (!rstn) privTrap);
    COV_MULTI: cover property (@(posedge mclk) disable iff (!rstn)
        (state_reg == ST_STEP) && !st.countZero);
    COV_LONG: cover property (@(posedge mclk) disable iff (!rstn)
        ioReq && ioAck && ioSize == BODR_LONG);
    COV_WRAP: cover property (@(posedge mclk) disable iff (!rstn)
        (state_reg == ST_STEP) && cnt_reg == 16'h0000);
endmodule
`default_nettype wire

// *** rtl/bodr_pkg.sv ***
// Package: shared constants and types for the block output decrement engine
`default_nettype none
package bodr_pkg;
    // Element size selects byte, word or longword variant
    typedef enum logic [1:0] {
        BODR_BYTE = 2'h0,
        BODR_WORD = 2'h1,
        BODR_LONG = 2'h2
    } bodr_size_t;

    localparam int          BODR_ADDR_W   = 32;
    localparam int          BODR_PORT_W   = 16;
    localparam int          BODR_CNT_W    = 16;
    localparam int          BODR_DATA_W   = 32;
    localparam int          BODR_FLAG_W   = 6;
    // Flag bit positions: carry, zero, sign, overflow, decimal, half carry
    localparam int          BODR_FLAG_C   = 0;
    localparam int          BODR_FLAG_Z   = 1;
    localparam int          BODR_FLAG_S   = 2;
    localparam int          BODR_FLAG_V   = 3;
    localparam int          BODR_FLAG_D   = 4;
    localparam int          BODR_FLAG_H   = 5;
    // Pointer steps per variant
    localparam logic [31:0] BODR_STEP_B   = 32'h0000_0001;
    localparam logic [31:0] BODR_STEP_W   = 32'h0000_0002;
    localparam logic [31:0] BODR_STEP_L   = 32'h0000_0004;
    // Reset values
    localparam logic [31:0] BODR_PTR_RST  = 32'h0000_0000;
    localparam logic [15:0] BODR_CNT_RST  = 16'h0000;
    localparam logic [15:0] BODR_PORT_RST = 16'h0000;
    localparam logic [5:0]  BODR_FLAG_RST = 6'h00;
endpackage
`default_nettype wire

// *** rtl/bodr_step.sv ***
// Step unit: next source pointer and next counter value for one pass
`default_nettype none
module bodr_step
    import bodr_pkg::*;
(
    bodr_step_if.stepper st
);
    logic [31:0] stepSize;
    logic [31:0] linNext;

    // Element size picks the decrement amount
    always_comb begin
        case (st.size)
            BODR_BYTE: stepSize = BODR_STEP_B;
            BODR_WORD: stepSize = BODR_STEP_W;
            BODR_LONG: stepSize = BODR_STEP_L;
            default:   stepSize = BODR_STEP_W;
        endcase
    end

    // Compact mode wraps inside one word register
    assign linNext      = st.ptr - stepSize;
    assign st.ptrNext   = st.linear ? linNext : {16'h0000, linNext[15:0]};
    // Zero test follows the decrement, so zero start means 65536 passes
    assign st.countNext = st.count - 16'h0001;
    assign st.countZero = (st.countNext == 16'h0000);
endmodule
`default_nettype wire

// *** rtl/bodr_step_if.sv ***
// Interface: carries pointer and counter between engine and step unit
`default_nettype none
interface bodr_step_if;
    import bodr_pkg::*;
    logic [31:0] ptr;
    logic [15:0] count;
    bodr_size_t  size;
    logic        linear;
    logic [31:0] ptrNext;
    logic [15:0] countNext;
    logic        countZero;
    modport engine (output ptr, count, size, linear, input ptrNext, countNext, countZero);
    modport stepper (input ptr, count, size, linear, output ptrNext, countNext, countZero);
endinterface
`default_nettype wire

// *** testbench/block_output_decrement_repeat_test.sv ***
// Testbench: random block outputs of every size and mode, plus a refused start
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", nm, ex, got); end end
module block_output_decrement_repeat_test
    import bodr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, rstn, start, sysMode, linearMode, slow, memReq, memAck, ioReq, ioAck;
    logic        busy, done, privTrap;
    bodr_size_t  elemSize, memSize, ioSize;
    logic [31:0] srcPtrIn, memAddr, memData, ioData, srcPtrOut, seed;
    logic [15:0] portAddrIn, countIn, ioPort, countOut, portAddrOut;
    logic [5:0]  flagsIn, flagsOut;
    logic [49:0] ioQ[$];
    logic [54:0] doneQ[$];
    logic [49:0] ei;
    logic [54:0] ed;
    logic [31:0] zp;
    int          mismatches, n_checks;
    bodr_engine dut (.mclk(mclk), .rstn(rstn), .start(start), .elemSize(elemSize),
        .sysMode(sysMode), .linearMode(linearMode), .srcPtrIn(srcPtrIn), .portAddrIn(portAddrIn),
        .countIn(countIn), .flagsIn(flagsIn), .memReq(memReq), .memAddr(memAddr),
        .memSize(memSize), .memAck(memAck), .memData(memData), .ioReq(ioReq), .ioPort(ioPort),
        .ioData(ioData), .ioSize(ioSize), .ioAck(ioAck), .busy(busy), .done(done),
        .privTrap(privTrap), .srcPtrOut(srcPtrOut), .countOut(countOut),
        .portAddrOut(portAddrOut), .flagsOut(flagsOut));
    bodr_io_partner peer (.mclk(mclk), .slow(slow), .memReq(memReq), .memAddr(memAddr),
        .memSize(memSize), .memAck(memAck), .memData(memData), .ioReq(ioReq), .ioAck(ioAck));
    // ==========
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] mdat(logic [31:0] a, bodr_size_t s);
        logic [31:0] v;
        v = a * 32'h9E3779B1;
        return (s == BODR_BYTE) ? {24'h0, v[7:0]} : (s == BODR_WORD) ? {16'h0, v[15:0]} : v;
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Issue one run and note every expected transfer and the final state
    task automatic go(bodr_size_t sz, logic lin, logic sys, logic [15:0] cnt);
        logic [31:0] p, r;
        logic [15:0] port;
        logic [5:0]  fl;
        int          k;
        p = rnd();
        r = rnd();
        port = r[15:0];
        fl = r[21:16];
        @(negedge mclk);
        start = 1'b1;
        elemSize = sz;
        sysMode = sys;
        linearMode = lin;
        srcPtrIn = p;
        portAddrIn = port;
        countIn = cnt;
        flagsIn = fl;
        slow = r[31];
        if (!lin) p = {16'h0, p[15:0]};
        for (int i = 0; sys && i < int'(cnt); i++) begin
            ioQ.push_back({port, mdat(p, sz), sz});
            p = lin ? p - (32'h1 << sz) : {16'h0, p[15:0] - (16'h1 << sz)};
        end
        doneQ.push_back({!sys, p, 16'h0, fl | 6'h08});
        @(negedge mclk);
        start = 1'b0;
        k = 0;
        @(negedge mclk);
        while (busy && k < 400) begin
            @(negedge mclk);
            k++;
        end
        `CHK("idle", 1'b0, busy);
    endtask
    // ==========
    // Monitor: each transfer or completion retires the oldest note
    always @(posedge mclk) begin
        if (rstn && ioReq && ioAck) begin
            ei = ioQ.size() ? ioQ.pop_front() : '1;
            `CHK("ioPort", ei[49:34], ioPort);
            `CHK("ioData", ei[33:2], ioData);
            `CHK("ioSize", bodr_size_t'(ei[1:0]), ioSize);
        end
        if (rstn && (done || privTrap)) begin
            ed = doneQ.size() ? doneQ.pop_front() : '1;
            `CHK("trap", ed[54], privTrap);
            if (!ed[54]) begin
                `CHK("srcPtrOut", ed[53:22], srcPtrOut);
                `CHK("countOut", ed[21:6], countOut);
                `CHK("flagsOut", ed[5:0], flagsOut);
                `CHK("portAddrOut", portAddrIn, portAddrOut);
            end
        end
    end
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #200_000;
        mismatches++;
        wrap_up();
    end
    // ==========
    // Main sequence
    initial begin
        seed = 32'hC181E8B9;
        {rstn, start, sysMode, linearMode, slow} = 5'h0;
        {srcPtrIn, portAddrIn, countIn, flagsIn} = 70'h0;
        elemSize = BODR_WORD;
        mismatches = 0;
        n_checks = 0;
        repeat (20) @(negedge mclk);
        rstn = 1'b1;
        for (int n = 0; n < 12; n++) begin
            for (int s = 0; s < 3; s++) begin
                go(bodr_size_t'(s), n[0], 1'b1, {14'h0, n[2:1]} + 16'h1);
            end
        end
        go(BODR_WORD, 1'b1, 1'b0, 16'h0003);
        // Zero count wraps to the maximum; a mid-run reset cuts the run short
        zp = rnd();
        zp[31:16] = 16'h0000;
        @(negedge mclk);
        {start, sysMode, linearMode, slow} = 4'hC;
        elemSize = BODR_BYTE;
        srcPtrIn = zp;
        countIn = 16'h0000;
        for (int i = 0; i < 3; i++) begin
            ioQ.push_back({portAddrIn, mdat(zp, BODR_BYTE), BODR_BYTE});
            zp[15:0] = zp[15:0] - 16'h0001;
        end
        @(negedge mclk);
        start = 1'b0;
        repeat (9) @(negedge mclk);
        `CHK("wrapCount", 16'hFFFD, countOut);
        `CHK("wrapBusy", 1'b1, busy);
        `CHK("wrapPtr", zp, srcPtrOut);
        rstn = 1'b0;
        repeat (2) @(negedge mclk);
        `CHK("rstBusy", 1'b0, busy);
        `CHK("rstCount", BODR_CNT_RST, countOut);
        rstn = 1'b1;
        go(BODR_LONG, 1'b0, 1'b1, 16'h0006);
        repeat (5) @(negedge mclk);
        `CHK("leftover", 0, ioQ.size() + doneQ.size());
        wrap_up();
    end
endmodule
`undef CHK
`default_nettype wire

// *** testbench/bodr_io_partner.sv ***
// Partner model: memory and I/O port peripheral that answer the engine
`default_nettype none
module bodr_io_partner
    import bodr_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        slow,
    input  wire logic        memReq,
    input  wire logic [31:0] memAddr,
    input  wire bodr_size_t  memSize,
    output logic             memAck,
    output logic [31:0]      memData,
    input  wire logic        ioReq,
    output logic             ioAck
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] tick;
    logic       memGo;
    // ==========
    // Memory contents: a scramble of the address, right-aligned to the size
    function automatic logic [31:0] pattern(logic [31:0] a, bodr_size_t s);
        logic [31:0] v;
        v = a * 32'h9E3779B1;
        return (s == BODR_BYTE) ? {24'h0, v[7:0]} : (s == BODR_WORD) ? {16'h0, v[15:0]} : v;
    endfunction
    assign memGo = memReq && !memAck && (!slow || tick == 2'h3);
    initial begin
        memAck = 1'b0;
        ioAck = 1'b0;
        memData = 32'h0;
        tick = 2'h0;
    end
    // One-cycle acks, delayed when slow; data inverts outside an ack
    always @(negedge mclk) begin
        tick <= tick + 2'h1;
        memAck <= memGo;
        ioAck <= ioReq && !ioAck && (!slow || tick == 2'h1);
        memData <= memGo ? pattern(memAddr, memSize) : ~memData;
    end
endmodule
`default_nettype wire
